// File: rtl/ethfb_device.sv
// MAC buffer engine: transmit header parsing and receive frame information
//
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ethfb_device
    import ethfb_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    ethfb_link_if.dev_mp lnk,
    output logic [31:0] line_tx_data,
    output logic line_tx_valid,
    output logic line_tx_last,
    output logic [1:0] tx_last_word_valid_bytes,
    output logic [1:0] line_tx_port_sel,
    output logic line_tx_force,
    output logic line_tx_stamp,
    output logic line_tx_accel,
    output logic line_tx_len_error,
    input wire logic line_tx_ready,
    output logic tx_dma_done,
    output logic tx_line_done,
    input wire logic line_rx_valid,
    output logic line_rx_ready,
    input wire logic [31:0] line_rx_data,
    input wire logic line_rx_last,
    input wire logic [1:0] line_rx_last_bytes,
    input wire logic line_rx_fifo_ovf,
    input wire logic line_rx_ipv6,
    input wire logic [7:0] line_rx_ext_proto,
    input wire logic line_rx_ext_len_bad,
    input wire logic line_rx_ip_err,
    input wire logic line_rx_l4_err,
    input wire logic line_rx_is_ip,
    input wire logic line_rx_filter_hit,
    input wire logic line_rx_pppoe,
    input wire logic line_rx_vlan,
    input wire logic line_rx_l4_frame,
    input wire logic [15:0] line_rx_l4_sum,
    output logic rx_frame_done
);
    // Transmit side
    dev_tx_state_t tst_r;
    logic [31:0] hdr0_r;
    logic [12:0] left_r;
    logic [31:0] otd_r;
    logic otv_r;
    logic otl_r;
    logic [1:0] eob_r;
    logic [1:0] port_r;
    logic force_r;
    logic stamp_r;
    logic accel_r;
    logic lenerr_r;
    logic dma_r;
    logic done_r;

    wire tx_take = lnk.tx_valid && lnk.tx_ready;
    wire ltx_pop = otv_r && line_tx_ready;
    wire body_last = left_r == 13'h0001;
    wire [12:0] hdr_words = hdr0_r[HDR_WORDS_LSB +: WCNT_W];
    wire [1:0] hdr_eob = hdr0_r[HDR_EOB_LSB +: 2];
    wire [14:0] want_len = frame_bytes(hdr_words, hdr_eob) - pad_size(lnk.accel_en) + LEN_ADJ;
    wire opt_on = lnk.mtag_en;
    wire hdr_force = hdr0_r[HDR_FORCE_BIT] && opt_on;

    assign lnk.tx_ready = tst_r != T_BODY || !otv_r || line_tx_ready;
    assign line_tx_data = otd_r;
    assign line_tx_valid = otv_r;
    assign line_tx_last = otl_r;
    assign tx_last_word_valid_bytes = eob_r;
    assign line_tx_port_sel = port_r;
    assign line_tx_force = force_r;
    assign line_tx_stamp = stamp_r;
    assign line_tx_accel = accel_r;
    assign line_tx_len_error = lenerr_r;
    assign tx_dma_done = dma_r;
    assign tx_line_done = done_r;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tst_r <= T_HDR0;
            hdr0_r <= 32'h0;
            left_r <= 13'h0;
            eob_r <= EOB_1B;
            port_r <= 2'h0;
            force_r <= 1'b0;
            stamp_r <= 1'b0;
            accel_r <= 1'b0;
            lenerr_r <= 1'b0;
        end else if (tx_take) begin
            unique case (tst_r)
                T_HDR0: begin
                    hdr0_r <= lnk.tx_data;
                    tst_r <= T_HDR1;
                end
                T_HDR1: begin
                    left_r <= hdr_words;
                    eob_r <= hdr_eob;
                    force_r <= hdr_force;
                    port_r <= hdr_force ? {hdr0_r[HDR_PORT1_BIT], hdr0_r[HDR_PORT0_BIT]} : 2'h0;
                    stamp_r <= hdr0_r[HDR_STAMP_BIT] && opt_on;
                    accel_r <= lnk.accel_en;
                    lenerr_r <= lnk.tx_data[LEN_W-1:0] != want_len;
                    tst_r <= T_BODY;
                end
                T_BODY: begin
                    left_r <= left_r - 13'h0001;
                    if (body_last) begin
                        tst_r <= T_HDR0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            otd_r <= 32'h0;
            otv_r <= 1'b0;
            otl_r <= 1'b0;
            dma_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            dma_r <= tx_take && tst_r == T_BODY && body_last;
            done_r <= ltx_pop && otl_r;
            if (tx_take && tst_r == T_BODY) begin
                otd_r <= lnk.tx_data;
                otv_r <= 1'b1;
                otl_r <= body_last;
            end else if (ltx_pop) begin
                otv_r <= 1'b0;
            end
        end
    end

    // Receive side: two-entry buffer toward the controller
    dev_rx_state_t rst_r;
    logic [32:0] mem_r [2];
    logic wp_r;
    logic rp_r;
    logic [1:0] cnt_r;
    logic odd_r;
    logic ovf_r;
    logic [15:0] bytes_r;
    logic [8:0] flags_r;
    logic fin_r;

    wire full = cnt_r == 2'h2;
    wire pop = lnk.rx_valid && lnk.rx_ready;
    wire take = line_rx_valid && line_rx_ready;
    wire ext_len_type = line_rx_ext_proto == PROTO_HOPBYHOP || line_rx_ext_proto == PROTO_ROUTING ||
                        line_rx_ext_proto == PROTO_DSTOPT;
    wire listed = ext_len_type || line_rx_ext_proto == PROTO_TCP || line_rx_ext_proto == PROTO_UDP ||
                  line_rx_ext_proto == PROTO_FRAG || line_rx_ext_proto == PROTO_NONEXT ||
                  line_rx_ext_proto == PROTO_ESP || line_rx_ext_proto == PROTO_AH;
    wire acc = lnk.accel_en;
    wire v6err = line_rx_ipv6 && ext_len_type && line_rx_ext_len_bad;
    wire unlisted_protocol_flag = line_rx_ipv6 && !listed;
    wire [7:0] parse_flags = {line_rx_vlan, line_rx_pppoe, line_rx_filter_hit, line_rx_is_ip,
                              unlisted_protocol_flag, v6err, line_rx_l4_err, line_rx_ip_err};
    wire ovf_now = ovf_r || line_rx_fifo_ovf || (take && full);
    wire [15:0] last_bytes = bytes_r + {14'h0, line_rx_last_bytes} + 16'h0001 +
                             (acc ? RX_ACCEL_PAD : 16'h0000);
    wire fcs_swap = line_rx_last && acc && line_rx_l4_frame;
    wire [31:0] in_word = fcs_swap ? {16'h0000, line_rx_l4_sum} : line_rx_data;
    wire push = rst_r == R_DATA ? take && !full : !full;
    wire [32:0] push_word = rst_r == R_DATA ? {1'b0, in_word} :
                            rst_r == R_PAD ? 33'h000000000 :
                            rst_r == R_INF0 ? {17'h00000, bytes_r} :
                            {1'b1, 23'h000000, flags_r};
    wire odd_nxt = odd_r ^ push;

    assign line_rx_ready = rst_r == R_DATA;
    assign lnk.rx_valid = cnt_r != 2'h0;
    assign lnk.rx_data = mem_r[rp_r][31:0];
    assign lnk.rx_last = mem_r[rp_r][32];
    assign rx_frame_done = fin_r;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mem_r[0] <= 33'h000000000;
            mem_r[1] <= 33'h000000000;
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (push) begin
                mem_r[wp_r] <= push_word;
                wp_r <= ~wp_r;
            end
            if (pop) begin
                rp_r <= ~rp_r;
            end
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rst_r <= R_DATA;
            odd_r <= 1'b0;
            ovf_r <= 1'b0;
            bytes_r <= 16'h0;
            flags_r <= 9'h0;
            fin_r <= 1'b0;
        end else begin
            fin_r <= rst_r == R_INF1 && push;
            unique case (rst_r)
                R_DATA: begin
                    ovf_r <= ovf_now;
                    odd_r <= odd_nxt;
                    if (take && line_rx_last) begin
                        bytes_r <= last_bytes;
                        flags_r <= {ovf_now, acc ? parse_flags : 8'h00};
                        rst_r <= odd_nxt ? R_PAD : R_INF0;
                    end else if (take) begin
                        bytes_r <= bytes_r + RX_WORD_BYTES;
                    end
                end
                R_PAD: begin
                    if (push) begin
                        rst_r <= R_INF0;
                    end
                end
                R_INF0: begin
                    if (push) begin
                        rst_r <= R_INF1;
                    end
                end
                R_INF1: begin
                    if (push) begin
                        rst_r <= R_DATA;
                        odd_r <= 1'b0;
                        ovf_r <= 1'b0;
                        bytes_r <= 16'h0;
                    end
                end
            endcase
        end
    end
endmodule : ethfb_device
`default_nettype wire

// File: rtl/ethfb_host.sv
// Buffer controller: Wishbone registers to transmit words, receive words to software
`timescale 1ns/1ps
`default_nettype none
module ethfb_host
    import ethfb_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    ethfb_link_if.host_mp lnk
);
    host_tx_state_t st_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic [1:0] ctrl_r;
    logic [31:0] txd_r;
    logic txv_r;
    logic txlast_r;
    logic [31:0] hdr1_r;
    logic [12:0] left_r;

    wire req = cyc_i && stb_i && !ack_r;
    wire hit_ctrl = adr_i == ADDR_CTRL;
    wire hit_cfg = adr_i == ADDR_TXCFG;
    wire hit_txd = adr_i == ADDR_TXDATA;
    wire hit_rxd = adr_i == ADDR_RXDATA;
    wire hit_stat = adr_i == ADDR_STAT;
    wire wr_stall = we_i && (hit_cfg || hit_txd) && txv_r;
    wire do_ack = req && !wr_stall;
    wire wr_ctrl = do_ack && we_i && hit_ctrl && sel_i[0];
    wire wr_cfg = do_ack && we_i && hit_cfg && st_r == H_IDLE;
    wire wr_txd = do_ack && we_i && hit_txd && st_r == H_BODY;
    wire rd_rxd = do_ack && !we_i && hit_rxd;
    wire tx_take = txv_r && lnk.tx_ready;
    wire [12:0] cfg_words = dat_i[HDR_WORDS_LSB +: WCNT_W];
    wire [1:0] cfg_eob = dat_i[HDR_EOB_LSB +: 2];
    wire [14:0] cfg_len = frame_bytes(cfg_words, cfg_eob) - pad_size(ctrl_r[CTRL_ACCEL_BIT]) + LEN_ADJ;
    wire busy = st_r != H_IDLE || txv_r;
    wire [31:0] stat_word = {29'h0, busy, lnk.rx_last, lnk.rx_valid};
    wire [31:0] rd_word = hit_ctrl ? {30'h0, ctrl_r} :
                          hit_stat ? stat_word :
                          (hit_rxd && lnk.rx_valid) ? lnk.rx_data : 32'h0;

    assign dat_o = dat_r;
    assign ack_o = ack_r;
    assign lnk.tx_data = txd_r;
    assign lnk.tx_valid = txv_r;
    assign lnk.tx_last = txlast_r;
    assign lnk.rx_ready = rd_rxd;
    assign lnk.accel_en = ctrl_r[CTRL_ACCEL_BIT];
    assign lnk.mtag_en = ctrl_r[CTRL_MTAG_BIT];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
            ctrl_r <= CTRL_RESET;
        end else begin
            ack_r <= do_ack;
            if (do_ack && !we_i) begin
                dat_r <= rd_word;
            end
            if (wr_ctrl) begin
                ctrl_r <= dat_i[1:0];
            end
        end
    end

    // Header words go out first, then the frame words
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r <= H_IDLE;
            txd_r <= 32'h0;
            txv_r <= 1'b0;
            txlast_r <= 1'b0;
            hdr1_r <= 32'h0;
            left_r <= 13'h0;
        end else if (wr_cfg) begin
            txd_r <= dat_i & HDR0_MASK;
            txv_r <= 1'b1;
            txlast_r <= 1'b0;
            hdr1_r <= {17'h0, cfg_len};
            left_r <= cfg_words;
            st_r <= H_HDR1;
        end else if (wr_txd) begin
            txd_r <= dat_i;
            txv_r <= 1'b1;
            txlast_r <= left_r == 13'h0001;
            left_r <= left_r - 13'h0001;
        end else if (tx_take) begin
            if (st_r == H_HDR1) begin
                txd_r <= hdr1_r;
                st_r <= H_BODY;
            end else begin
                txv_r <= 1'b0;
                txlast_r <= 1'b0;
                if (txlast_r) begin
                    st_r <= H_IDLE;
                end
            end
        end
    end
endmodule : ethfb_host
`default_nettype wire

// File: rtl/ethfb_link_if.sv
// Word link between the buffer controller and the MAC buffer engine
`timescale 1ns/1ps
`default_nettype none
interface ethfb_link_if;
    logic [31:0] tx_data;
    logic tx_valid;
    logic tx_ready;
    logic tx_last;
    logic [31:0] rx_data;
    logic rx_valid;
    logic rx_ready;
    logic rx_last;
    logic accel_en;
    logic mtag_en;
    modport host_mp(output tx_data, tx_valid, tx_last, rx_ready, accel_en, mtag_en,
                    input tx_ready, rx_data, rx_valid, rx_last);
    modport dev_mp(input tx_data, tx_valid, tx_last, rx_ready, accel_en, mtag_en,
                   output tx_ready, rx_data, rx_valid, rx_last);
endinterface : ethfb_link_if
`default_nettype wire

// File: rtl/ethfb_pkg.sv
// Shared constants, field layouts and state types for the frame-buffer link
package ethfb_pkg;
    localparam int WORD_W = 32;
    localparam int WCNT_W = 13;
    localparam int LEN_W = 15;
    localparam int RXCNT_W = 16;
    // Transmit header word 0 layout
    localparam int HDR_WORDS_LSB = 0;
    localparam int HDR_EOB_LSB = 13;
    localparam int HDR_PORT0_BIT = 16;
    localparam int HDR_PORT1_BIT = 17;
    localparam int HDR_FORCE_BIT = 18;
    localparam int HDR_STAMP_BIT = 19;
    localparam logic [31:0] HDR0_MASK = 32'h000F7FFF;
    // Last-word valid byte codes
    localparam logic [1:0] EOB_1B = 2'h0;
    localparam logic [1:0] EOB_2B = 2'h1;
    localparam logic [1:0] EOB_3B = 2'h2;
    localparam logic [1:0] EOB_4B = 2'h3;
    // Length formula terms
    localparam logic [14:0] PAD_ACCEL_ON = 15'h0002;
    localparam logic [14:0] PAD_ACCEL_OFF = 15'h0000;
    localparam logic [14:0] LEN_ADJ = 15'h0003;
    localparam logic [15:0] RX_ACCEL_PAD = 16'h0002;
    localparam logic [15:0] RX_WORD_BYTES = 16'h0004;
    // IPv6 next-header codes
    localparam logic [7:0] PROTO_TCP = 8'h06;
    localparam logic [7:0] PROTO_UDP = 8'h11;
    localparam logic [7:0] PROTO_HOPBYHOP = 8'h00;
    localparam logic [7:0] PROTO_DSTOPT = 8'h3C;
    localparam logic [7:0] PROTO_FRAG = 8'h2C;
    localparam logic [7:0] PROTO_ROUTING = 8'h2B;
    localparam logic [7:0] PROTO_NONEXT = 8'h3B;
    localparam logic [7:0] PROTO_ESP = 8'h32;
    localparam logic [7:0] PROTO_AH = 8'h33;
    // Receive information word 1 bits
    localparam int INF_IPERR_BIT = 0;
    localparam int INF_L4ERR_BIT = 1;
    localparam int INF_V6ERR_BIT = 2;
    localparam int INF_UNLIST_BIT = 3;
    localparam int INF_ISIP_BIT = 4;
    localparam int INF_FILT_BIT = 5;
    localparam int INF_PPPOE_BIT = 6;
    localparam int INF_VLAN_BIT = 7;
    localparam int INF_OVF_BIT = 8;
    // Controller register offsets and bits
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TXCFG = 8'h04;
    localparam logic [7:0] ADDR_TXDATA = 8'h08;
    localparam logic [7:0] ADDR_RXDATA = 8'h0C;
    localparam logic [7:0] ADDR_STAT = 8'h10;
    localparam int CTRL_ACCEL_BIT = 0;
    localparam int CTRL_MTAG_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    typedef enum logic [1:0] {T_HDR0, T_HDR1, T_BODY} dev_tx_state_t;
    typedef enum logic [1:0] {R_DATA, R_PAD, R_INF0, R_INF1} dev_rx_state_t;
    typedef enum logic [1:0] {H_IDLE, H_HDR1, H_BODY} host_tx_state_t;

    function automatic logic [14:0] pad_size(input logic accel);
        pad_size = accel ? PAD_ACCEL_ON : PAD_ACCEL_OFF;
    endfunction : pad_size

    function automatic logic [14:0] frame_bytes(input logic [12:0] words, input logic [1:0] eob);
        frame_bytes = {words - 13'h0001, 2'b00} + {13'h0000, eob} + 15'h0001;
    endfunction : frame_bytes
endpackage : ethfb_pkg

// File: testbench/ethfb_props.sv
// Link protocol assertions for the frame-buffer link
`timescale 1ns/1ps
`default_nettype none
module ethfb_props (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [31:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic tx_last,
    input wire logic [31:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic rx_last,
    input wire logic accel_en,
    input wire logic mtag_en
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [15:0] rx_cnt_r;
    logic [15:0] rx_cnt_nxt;
    assign rx_cnt_nxt = rx_last ? 16'h0000 : rx_cnt_r + 16'h0001;
    // Words popped since the last info word
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_cnt_r <= 16'h0000;
        end else if (rx_valid && rx_ready) begin
            rx_cnt_r <= rx_cnt_nxt;
        end
    end
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
        else $error("tx word changed before acceptance");
    tx_last_a: assert property (tx_last |-> tx_valid)
        else $error("tx last marker without a word");
    rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data) && $stable(rx_last))
        else $error("rx word changed before acceptance");
    rx_last_a: assert property (rx_last |-> rx_valid)
        else $error("rx last marker without a word");
    rx_flags_a: assert property (rx_valid && rx_last && !accel_en |-> rx_data[7:0] == 8'h00)
        else $error("parse flags set without accelerator");
    rx_spare_a: assert property (rx_valid && rx_last |-> rx_data[31:9] == 23'h000000)
        else $error("info word spare bits set");
    rx_align_a: assert property (rx_valid && rx_ready && rx_last |-> rx_cnt_r[0])
        else $error("frame block not a whole number of 64-bit units");
    rx_pulse_a: assert property (rx_ready |=> !rx_ready)
        else $error("rx pop longer than one cycle");
    cover property (tx_valid && !tx_ready);
    cover property (tx_valid && tx_ready && tx_last && mtag_en);
    cover property (rx_valid && rx_ready && rx_last && rx_data[8]);
endmodule : ethfb_props
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the buffer controller and MAC buffer engine
`timescale 1ns/1ps
`default_nettype none
module tb
    import ethfb_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic cyc_i, stb_i, we_i, ack_o, stall;
    logic [7:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, rd, line_tx_data, line_rx_data;
    logic line_tx_valid, line_tx_last, line_tx_force, line_tx_stamp, line_tx_accel, line_tx_len_error;
    logic [1:0] tx_last_word_valid_bytes, line_tx_port_sel, line_rx_last_bytes;
    logic line_tx_ready, tx_dma_done, tx_line_done, line_rx_valid, line_rx_ready, line_rx_last, line_rx_fifo_ovf;
    logic line_rx_ipv6, line_rx_ext_len_bad, line_rx_ip_err, line_rx_l4_err, line_rx_is_ip, line_rx_filter_hit;
    logic line_rx_pppoe, line_rx_vlan, line_rx_l4_frame, rx_frame_done;
    logic [7:0] line_rx_ext_proto;
    logic [15:0] line_rx_l4_sum;
    logic [8:0] cap = 9'h000;
    logic [31:0] tx_seen[$];
    logic [31:0] lnk_seen[$];
    logic [31:0] flg_exp;
    logic [7:0] codes [10] = '{8'h06, 8'h11, 8'h00, 8'h3C, 8'h2C, 8'h2B, 8'h3B, 8'h32, 8'h33, 8'h99};
    int errors = 0, num_checks = 0, dma_cnt = 0, line_cnt = 0, rx_done_cnt = 0, cyc_cnt = 0;

    ethfb_link_if lnk ();
    ethfb_host i_ethfb_host (.clk_sys(clk_sys), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .lnk(lnk));
    ethfb_device i_ethfb_device (.clk_sys(clk_sys), .rst(rst), .lnk(lnk), .line_tx_data(line_tx_data),
        .line_tx_valid(line_tx_valid), .line_tx_last(line_tx_last), .line_tx_ready(line_tx_ready),
        .tx_last_word_valid_bytes(tx_last_word_valid_bytes), .line_tx_port_sel(line_tx_port_sel),
        .line_tx_force(line_tx_force), .line_tx_stamp(line_tx_stamp), .line_tx_accel(line_tx_accel),
        .line_tx_len_error(line_tx_len_error), .tx_dma_done(tx_dma_done), .tx_line_done(tx_line_done),
        .line_rx_valid(line_rx_valid), .line_rx_ready(line_rx_ready), .line_rx_data(line_rx_data),
        .line_rx_last(line_rx_last), .line_rx_last_bytes(line_rx_last_bytes), .line_rx_fifo_ovf(line_rx_fifo_ovf),
        .line_rx_ipv6(line_rx_ipv6), .line_rx_ext_proto(line_rx_ext_proto), .line_rx_ext_len_bad(line_rx_ext_len_bad),
        .line_rx_ip_err(line_rx_ip_err), .line_rx_l4_err(line_rx_l4_err), .line_rx_is_ip(line_rx_is_ip),
        .line_rx_filter_hit(line_rx_filter_hit), .line_rx_pppoe(line_rx_pppoe), .line_rx_vlan(line_rx_vlan),
        .line_rx_l4_frame(line_rx_l4_frame), .line_rx_l4_sum(line_rx_l4_sum), .rx_frame_done(rx_frame_done));
    ethfb_props u_props (.clk_sys(clk_sys), .rst(rst), .tx_data(lnk.tx_data), .tx_valid(lnk.tx_valid),
        .tx_ready(lnk.tx_ready), .tx_last(lnk.tx_last), .rx_data(lnk.rx_data), .rx_valid(lnk.rx_valid),
        .rx_ready(lnk.rx_ready), .rx_last(lnk.rx_last), .accel_en(lnk.accel_en), .mtag_en(lnk.mtag_en));

    always #50 clk_sys = ~clk_sys;

    // Line side: stalling sink, word capture and pulse counters
    always @(posedge clk_sys) begin
        cyc_cnt <= cyc_cnt + 1;
        line_tx_ready <= !stall || cyc_cnt[2];
        if (lnk.tx_valid === 1'b1 && lnk.tx_ready === 1'b1) lnk_seen.push_back(lnk.tx_data);
        if (line_tx_valid === 1'b1 && line_tx_ready === 1'b1) begin
            tx_seen.push_back(line_tx_data);
            if (line_tx_last === 1'b1) cap = {tx_last_word_valid_bytes, line_tx_port_sel, line_tx_force,
                line_tx_stamp, line_tx_accel, line_tx_len_error, 1'b1};
        end
        if (tx_dma_done === 1'b1) dma_cnt++;
        if (tx_line_done === 1'b1) line_cnt++;
        if (rx_frame_done === 1'b1) rx_done_cnt++;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    // Classic single Wishbone cycle, held until ack is sampled
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rdat);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= we;
        adr_i <= adr;
        dat_i <= wd;
        do @(posedge clk_sys); while (ack_o !== 1'b1);
        rdat = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_sys);
    endtask : wb_cycle

    task automatic tx_frame(input logic [1:0] f);
        logic [12:0] nw;
        logic [31:0] cfg;
        logic [8:0] opt_exp;
        nw = {11'h000, f} + 13'h0001;
        cfg = {12'h000, f[0], f != 2'h3, 1'b1, f[0], 1'b0, f, nw};
        opt_exp = {f, (f == 2'h2) ? 2'b10 : 2'b00, f == 2'h2, f == 2'h3, f[0], 2'b01};
        stall <= (f == 2'h3);
        wb_cycle(1'b1, ADDR_CTRL, {30'h0, f}, rd);
        wb_cycle(1'b1, ADDR_TXCFG, cfg, rd);
        for (int i = 0; i < nw; i++) wb_cycle(1'b1, ADDR_TXDATA, 32'hDA7A0000 + 32'(f) * 32'h10 + 32'(i), rd);
        for (int k = 0; k < 300 && line_cnt <= int'(f); k++) @(posedge clk_sys);
        check("tx_words", 32'(tx_seen.size()), 32'(nw));
        check("lnk_words", 32'(lnk_seen.size()), 32'(nw) + 32'h2);
        check("tx_hdr0", lnk_seen[0], cfg);
        check("tx_len", lnk_seen[1], 32'(4 * (nw - 1) + f + 1 - (f[0] ? 2 : 0) + 3));
        foreach (tx_seen[i]) check("tx_data", tx_seen[i], 32'hDA7A0000 + 32'(f) * 32'h10 + 32'(i));
        check("tx_opts", {23'h0, cap}, {23'h0, opt_exp});
        check("tx_dma_done", 32'(dma_cnt), 32'(f) + 32'h1);
        check("tx_line_done", 32'(line_cnt), 32'(f) + 32'h1);
        tx_seen.delete();
        lnk_seen.delete();
        cap = 9'h000;
    endtask : tx_frame

    task automatic parse(input logic [9:0] p, input logic [7:0] pr, input logic [15:0] sum);
        {line_rx_l4_frame, line_rx_fifo_ovf, line_rx_ipv6, line_rx_ext_len_bad, line_rx_vlan, line_rx_pppoe,
            line_rx_filter_hit, line_rx_is_ip, line_rx_l4_err, line_rx_ip_err} <= p;
        line_rx_ext_proto <= pr;
        line_rx_l4_sum <= sum;
    endtask : parse

    task automatic rx_frame(input int n, input logic [1:0] lb, input logic ac, input logic [31:0] lw,
        input logic [31:0] flg);
        logic [31:0] got[$];
        logic [31:0] st;
        int k;
        wb_cycle(1'b1, ADDR_CTRL, {31'h0, ac}, rd);
        for (int i = 0; i < n; i++) begin
            line_rx_valid <= 1'b1;
            line_rx_data <= 32'hC0DE0000 + 32'(i);
            line_rx_last <= (i == n - 1);
            line_rx_last_bytes <= lb;
            do @(posedge clk_sys); while (line_rx_ready !== 1'b1);
        end
        line_rx_valid <= 1'b0;
        line_rx_last <= 1'b0;
        line_rx_data <= ~line_rx_data;
        line_rx_fifo_ovf <= 1'b0;
        k = 0;
        do begin
            wb_cycle(1'b0, ADDR_STAT, 32'h0, st);
            if (st[0] === 1'b1) wb_cycle(1'b0, ADDR_RXDATA, 32'h0, rd);
            if (st[0] === 1'b1) got.push_back(rd);
            k++;
        end while (!(st[0] === 1'b1 && st[1] === 1'b1) && k < 60);
        if (n <= 2) begin
            check("rx_size", 32'(got.size()), 32'h4);
            check("rx_word0", got[0], 32'hC0DE0000);
            check("rx_word1", got[1], (n == 1) ? 32'h0 : lw);
        end
        check("rx_count", got[got.size() - 2], 32'(4 * (n - 1) + lb + 1 + (ac ? 2 : 0)));
        check("rx_flags", got[got.size() - 1], flg);
    endtask : rx_frame

    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        finish_test();
    end

    initial begin
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 8'h00;
        sel_i = 4'hF;
        dat_i = 32'h0;
        stall = 1'b0;
        line_rx_valid = 1'b0;
        line_rx_last = 1'b0;
        line_rx_data = 32'h0;
        line_rx_last_bytes = 2'h0;
        parse(10'h000, 8'h00, 16'h0000);
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        wb_cycle(1'b0, ADDR_STAT, 32'h0, rd);
        check("stat_reset", rd, 32'h0);
        wb_cycle(1'b1, ADDR_CTRL, 32'h3, rd);
        wb_cycle(1'b1, 8'h14, 32'hFFFFFFFF, rd);
        wb_cycle(1'b0, ADDR_CTRL, 32'h0, rd);
        check("ctrl", rd, 32'h3);
        wb_cycle(1'b0, 8'h14, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        wb_cycle(1'b1, ADDR_TXDATA, 32'h5A5A5A5A, rd);
        for (int f = 0; f < 4; f++) tx_frame(2'(f));
        parse(10'h3FF, 8'h99, 16'h1234);
        rx_frame(1, 2'h1, 1'b0, 32'h0, 32'h100);
        parse(10'h2AF, 8'h06, 16'hBEEF);
        rx_frame(2, 2'h3, 1'b1, 32'h0000BEEF, 32'hB3);
        foreach (codes[i]) begin
            parse(10'h0C0, codes[i], 16'h0000);
            flg_exp = {28'h0, codes[i] == 8'h99, codes[i] == 8'h00 || codes[i] == 8'h3C || codes[i] == 8'h2B, 2'b00};
            rx_frame(1, 2'h0, 1'b1, 32'h0, flg_exp);
        end
        parse(10'h000, 8'h00, 16'h0000);
        rx_frame(3, 2'h2, 1'b0, 32'h0, 32'h100);
        check("rx_done", 32'(rx_done_cnt), 32'h0000000D);
        wb_cycle(1'b0, ADDR_RXDATA, 32'h0, rd);
        check("rx_empty", rd, 32'h0);
        finish_test();
    end
endmodule : tb
`default_nettype wire
